// ---- rtl/srxl_regs.svh ----
// Purpose: Register map, field positions and timing counts of the receive lock block
// Assumes: 32-bit APB, one aligned word per register
// Notes: Bit periods are scaled so that the serial stream is sampled by clk_in
`ifndef SRXL_REGS_SVH
`define SRXL_REGS_SVH

`define SRXL_ADDR_CTRL 12'h000
`define SRXL_ADDR_STATUS 12'h004
`define SRXL_ADDR_INT_STAT 12'h008
`define SRXL_ADDR_INT_MASK 12'h00c

`define SRXL_CTRL_POLARITY 0
`define SRXL_CTRL_MUTE 1
`define SRXL_CTRL_FEC 2
`define SRXL_CTRL_ALT_REF 3
`define SRXL_CTRL_RESET 4'h0

`define SRXL_ST_SIG_LOSS 0
`define SRXL_ST_LOCK 1
`define SRXL_ST_REF_TRAINED 2
`define SRXL_ST_FREQ_OK 3

`define SRXL_EV_SIG_LOSS 0
`define SRXL_EV_LOCK_LOST 1
`define SRXL_EV_LOCK_GAINED 2
`define SRXL_INT_RESET 3'h0

// Serial bit period in clk_in cycles, standard and error-correction rate
`define SRXL_BIT_CYC_STD 4'h8
`define SRXL_BIT_CYC_FEC 4'h7
// Serial bits per reference period for the low and high reference frequency
`define SRXL_BITS_PER_REF_LO 32
`define SRXL_BITS_PER_REF_HI 16
`define SRXL_REF_TRAIN_TICKS 4'h8
`define SRXL_REF_SPACE_TOL 1
// Short window keeps relock time near 29k clocks at the high reference and error-correction rate
`define SRXL_WIN_REF_TICKS 256
`define SRXL_PPM_TOL 500
`define SRXL_FREQ_TOL_LO ((`SRXL_BITS_PER_REF_LO * `SRXL_WIN_REF_TICKS * `SRXL_PPM_TOL) / 1000000)
`define SRXL_FREQ_TOL_HI ((`SRXL_BITS_PER_REF_HI * `SRXL_WIN_REF_TICKS * `SRXL_PPM_TOL) / 1000000)

`endif

// ---- rtl/srxl_pkg.sv ----
// Purpose: Types shared by the receive lock and signal detect block
// Assumes: Nothing beyond the register header
// Notes: One-hot loop states
package srxl_pkg;
    typedef enum logic [2:0]
    {
        ST_REF_TRAIN = 3'b001,
        ST_REF_HOLD = 3'b010,
        ST_DATA_LOCK = 3'b100
    } srxl_state_t;
endpackage

// ---- rtl/srxl_top.sv ----
// Purpose: Receive clock recovery control, signal detect, mute and 4-lane deserializer
// Assumes: One clock clk_in at 250 MHz; serial data and reference arrive as pins
// Notes: Recovery is an oversampling model; the parallel clock is an output level
// Function
// - Train on reference before acquiring data
// - Deviation beyond tolerance returns loop to reference
// - Deviation fallback declares loss of lock
// - Keep supplying reference-based clock during losses
// - Inactive detect forces loss of lock, reference
// - Detect active and in tolerance relocks data
// - Loss condition is detect XOR polarity
// - Loss indicator output follows loss condition
// - Loss events reflected in status registers
// - Mute forces data zero during loss
// - Disable input zeroes data immediately, asynchronously
// - De-interleave bits onto four lanes
// - Standard and error-correction line rates supported
// - Parallel clock is recovered clock divided four
//
// Added by the designer: register access over APB and the register addresses.
`include "srxl_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module srxl_top
(
    input wire logic clk_in,                 // System clock, 250 MHz
    input wire logic srst_in,                // Synchronous reset, active high
    input wire logic psel_in,                // APB select
    input wire logic penable_in,             // APB enable
    input wire logic pwrite_in,              // APB direction
    input wire logic [11:0] paddr_in,        // APB byte address
    input wire logic [31:0] pwdata_in,       // APB write data
    output logic [31:0] prdata_out,          // APB read data
    output logic pready_out,                 // APB ready
    output logic pslverr_out,                // APB error on unmapped address
    input wire logic serial_rx_in,           // Serial receive data pin
    input wire logic local_ref_clk_in,       // Local reference clock pin
    input wire logic ext_signal_detect_in,   // Signal detect from optical module
    input wire logic rx_data_disable_in,     // Parallel data disable, active high
    output logic [3:0] rx_par_data_out,      // Parallel receive word
    output logic rx_par_clk_out,             // Parallel word clock
    output logic recovery_lock_ind_out,      // Lock indicator, high when on data
    output logic sig_loss_out,               // Loss of signal indicator
    output logic irq_out                     // Level interrupt
);
    import srxl_pkg::*;

    logic ref_meta, ref_sync, ref_prev;
    logic data_meta, data_sync, data_prev;
    logic sd_meta, sd_sync;
    logic [3:0] ctrl;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    srxl_state_t state;
    srxl_state_t next_state;
    logic ref_tick, data_edge;
    logic [3:0] bit_cyc;
    logic [11:0] ref_nominal;
    logic [11:0] ref_gap;
    logic [3:0] train_cnt;
    logic ref_trained;
    logic [3:0] dphase, rphase;
    logic data_strobe, ref_strobe, bit_strobe;
    logic [10:0] win_cnt;
    logic [16:0] bit_cnt;
    logic [16:0] bit_expect;
    logic [16:0] freq_tol;
    logic win_done, freq_ok;
    logic sig_loss_cond;
    logic sig_loss_q;
    logic [1:0] lane;
    logic [3:0] shift_word;
    logic [3:0] par_word;
    logic apb_access, apb_done;
    logic addr_ok;
    logic [2:0] ev;
    logic gap_in_tol;

    // Serial, reference and detect pins pass two flops before any logic reads them
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            ref_meta <= 1'b0;
            ref_sync <= 1'b0;
            ref_prev <= 1'b0;
            data_meta <= 1'b0;
            data_sync <= 1'b0;
            data_prev <= 1'b0;
            sd_meta <= 1'b0;
            sd_sync <= 1'b0;
        end
        else
        begin
            ref_meta <= local_ref_clk_in;
            ref_sync <= ref_meta;
            ref_prev <= ref_sync;
            data_meta <= serial_rx_in;
            data_sync <= data_meta;
            data_prev <= data_sync;
            sd_meta <= ext_signal_detect_in;
            sd_sync <= sd_meta;
        end
    end

    assign ref_tick = ref_sync & ~ref_prev;
    assign data_edge = data_sync ^ data_prev;

    assign bit_cyc = ctrl[`SRXL_CTRL_FEC] ? `SRXL_BIT_CYC_FEC : `SRXL_BIT_CYC_STD;
    assign ref_nominal = ctrl[`SRXL_CTRL_ALT_REF]
        ? 12'(`SRXL_BITS_PER_REF_HI) * {8'h00, bit_cyc}
        : 12'(`SRXL_BITS_PER_REF_LO) * {8'h00, bit_cyc};
    assign bit_expect = ctrl[`SRXL_CTRL_ALT_REF]
        ? 17'(`SRXL_BITS_PER_REF_HI * `SRXL_WIN_REF_TICKS)
        : 17'(`SRXL_BITS_PER_REF_LO * `SRXL_WIN_REF_TICKS);
    assign freq_tol = ctrl[`SRXL_CTRL_ALT_REF]
        ? 17'(`SRXL_FREQ_TOL_HI)
        : 17'(`SRXL_FREQ_TOL_LO);

    assign sig_loss_cond = sd_sync ^ ctrl[`SRXL_CTRL_POLARITY];

    assign gap_in_tol = (ref_gap + 12'(`SRXL_REF_SPACE_TOL) >= ref_nominal)
        && (ref_gap <= ref_nominal + 12'(`SRXL_REF_SPACE_TOL));

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            ref_gap <= 12'h000;
            train_cnt <= 4'h0;
            ref_trained <= 1'b0;
        end
        else if (ref_tick)
        begin
            ref_gap <= 12'h001;
            if (!gap_in_tol)
            begin
                train_cnt <= 4'h0;
                ref_trained <= 1'b0;
            end
            else if (train_cnt == `SRXL_REF_TRAIN_TICKS - 4'h1)
            begin
                ref_trained <= 1'b1;
            end
            else
            begin
                train_cnt <= train_cnt + 4'h1;
            end
        end
        else if (ref_gap != 12'hfff)
        begin
            ref_gap <= ref_gap + 12'h001;
        end
    end

    // Data tracking phase realigns on every transition, strobes mid-bit
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            dphase <= 4'h0;
        end
        else if (data_edge)
        begin
            dphase <= 4'h1;
        end
        else if (dphase >= bit_cyc - 4'h1)
        begin
            dphase <= 4'h0;
        end
        else
        begin
            dphase <= dphase + 4'h1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            rphase <= 4'h0;
        end
        else if (ref_tick || rphase >= bit_cyc - 4'h1)
        begin
            rphase <= 4'h0;
        end
        else
        begin
            rphase <= rphase + 4'h1;
        end
    end

    assign data_strobe = (dphase == {1'b0, bit_cyc[3:1]}) && !data_edge;
    assign ref_strobe = (rphase == bit_cyc - 4'h1);
    // reference clock drives the word clock unless locked on data
    assign bit_strobe = (state == ST_DATA_LOCK) ? data_strobe : ref_strobe;

    // Recovered bit count over a window of reference ticks
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            win_cnt <= 11'h000;
            bit_cnt <= 17'h00000;
            freq_ok <= 1'b0;
        end
        else
        begin
            if (ref_tick && win_cnt == 11'(`SRXL_WIN_REF_TICKS - 1))
            begin
                win_cnt <= 11'h000;
                bit_cnt <= {16'h0000, data_strobe};
                freq_ok <= (bit_cnt + freq_tol >= bit_expect) && (bit_cnt <= bit_expect + freq_tol);
            end
            else
            begin
                if (ref_tick)
                begin
                    win_cnt <= win_cnt + 11'h001;
                end
                if (data_strobe && bit_cnt != 17'h1ffff)
                begin
                    bit_cnt <= bit_cnt + 17'h00001;
                end
            end
        end
    end

    assign win_done = ref_tick && (win_cnt == 11'(`SRXL_WIN_REF_TICKS - 1));

    // Loop mode selection
    always_comb
    begin
        next_state = state;
        case (state)
            ST_REF_TRAIN:
            begin
                if (ref_trained)
                begin
                    next_state = ST_REF_HOLD;
                end
            end
            ST_REF_HOLD:
            begin
                if (win_done && !sig_loss_cond && ref_trained
                    && (bit_cnt + freq_tol >= bit_expect) && (bit_cnt <= bit_expect + freq_tol))
                begin
                    next_state = ST_DATA_LOCK;
                end
            end
            ST_DATA_LOCK:
            begin
                // detect inactive falls back at once
                if (sig_loss_cond)
                begin
                    next_state = ST_REF_HOLD;
                end
                else if (win_done
                    && !((bit_cnt + freq_tol >= bit_expect) && (bit_cnt <= bit_expect + freq_tol)))
                begin
                    next_state = ST_REF_HOLD;
                end
            end
            default:
            begin
                next_state = ST_REF_TRAIN;
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            state <= ST_REF_TRAIN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // lock indicator low whenever off data
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            recovery_lock_ind_out <= 1'b0;
        end
        else
        begin
            recovery_lock_ind_out <= (next_state == ST_DATA_LOCK);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            sig_loss_q <= 1'b0;
            sig_loss_out <= 1'b0;
        end
        else
        begin
            sig_loss_q <= sig_loss_cond;
            sig_loss_out <= sig_loss_cond;
        end
    end

    // de-interleave, earliest bit ends on lane 3
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            lane <= 2'h0;
            shift_word <= 4'h0;
        end
        else if (bit_strobe)
        begin
            shift_word <= {shift_word[2:0], data_sync};
            lane <= lane + 2'h1;
        end
    end

    // word clock: one period per four bits, rises mid-word
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            par_word <= 4'h0;
            rx_par_clk_out <= 1'b0;
        end
        else
        begin
            if (bit_strobe && lane == 2'h3)
            begin
                rx_par_clk_out <= 1'b0;
            end
            else if (bit_strobe && lane == 2'h1)
            begin
                rx_par_clk_out <= 1'b1;
            end
            // mute holds zero for the whole loss
            if (ctrl[`SRXL_CTRL_MUTE] && sig_loss_cond)
            begin
                par_word <= 4'h0;
            end
            else if (bit_strobe && lane == 2'h3)
            begin
                par_word <= {shift_word[2:0], data_sync};
            end
        end
    end

    // disable gates the pin straight through, no clock involved
    assign rx_par_data_out = par_word & {4{~rx_data_disable_in}};

    // APB slave: one wait state, read data captured into a flop
    assign apb_access = psel_in && penable_in;
    assign apb_done = apb_access && pready_out;
    assign addr_ok = (paddr_in == `SRXL_ADDR_CTRL) || (paddr_in == `SRXL_ADDR_STATUS)
        || (paddr_in == `SRXL_ADDR_INT_STAT) || (paddr_in == `SRXL_ADDR_INT_MASK);

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end
        else
        begin
            pready_out <= apb_access && !pready_out;
            pslverr_out <= apb_access && !pready_out && !addr_ok;
            prdata_out <= 32'h00000000;
            if (apb_access && !pready_out && !pwrite_in)
            begin
                case (paddr_in)
                    `SRXL_ADDR_CTRL: prdata_out <= {28'h0000000, ctrl};
                    `SRXL_ADDR_STATUS: prdata_out <= {28'h0000000, freq_ok, ref_trained,
                        recovery_lock_ind_out, sig_loss_q};
                    `SRXL_ADDR_INT_STAT: prdata_out <= {29'h00000000, int_stat};
                    `SRXL_ADDR_INT_MASK: prdata_out <= {29'h00000000, int_mask};
                    default: prdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            ctrl <= `SRXL_CTRL_RESET;
            int_mask <= `SRXL_INT_RESET;
        end
        else if (apb_done && pwrite_in)
        begin
            if (paddr_in == `SRXL_ADDR_CTRL)
            begin
                ctrl <= pwdata_in[3:0];
            end
            if (paddr_in == `SRXL_ADDR_INT_MASK)
            begin
                int_mask <= pwdata_in[2:0];
            end
        end
    end

    assign ev[`SRXL_EV_SIG_LOSS] = sig_loss_cond && !sig_loss_q;
    assign ev[`SRXL_EV_LOCK_LOST] = (state == ST_DATA_LOCK) && (next_state != ST_DATA_LOCK);
    assign ev[`SRXL_EV_LOCK_GAINED] = (state != ST_DATA_LOCK) && (next_state == ST_DATA_LOCK);

    // sticky events, set beats write-one clear
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            int_stat <= `SRXL_INT_RESET;
            irq_out <= 1'b0;
        end
        else
        begin
            if (apb_done && pwrite_in && paddr_in == `SRXL_ADDR_INT_STAT)
            begin
                int_stat <= (int_stat & ~pwdata_in[2:0]) | ev;
            end
            else
            begin
                int_stat <= int_stat | ev;
            end
            irq_out <= |(int_stat & int_mask);
        end
    end

endmodule // srxl_top

`default_nettype wire

// ---- dv/srxl_far_model.sv ----
// Purpose: Optical module and line source driving the serial and reference pins
// Assumes: Error-correction rate with the high reference selected
// Notes: Repeats one nibble so words can be predicted
`timescale 1ns/1ps
`default_nettype none
module srxl_far_model
(
    input wire logic clk_in,       // Bench clock
    input wire logic [3:0] nib_in, // Nibble, bit 3 sent first
    output logic serial_out,       // Serial line
    output logic ref_out           // Reference pin
);
    int bc = 0;
    int rc = 0;
    int bi = 0;
    initial serial_out = 1'b0;
    initial ref_out = 1'b0;
    // Seven clocks a bit, sixteen bits a reference period
    always @(posedge clk_in)
    begin
        rc <= (rc == 111) ? 0 : rc + 1;
        ref_out <= rc < 56;
        if (bc == 6)
        begin
            bc <= 0;
            bi <= (bi + 1) % 4;
            serial_out <= nib_in[3 - bi];
        end
        else
            bc <= bc + 1;
    end
endmodule // srxl_far_model
`default_nettype wire

// ---- dv/srxl_top_properties.sv ----
// Purpose: Port-level checks of the receive lock block
// Assumes: Sees only the top ports
// Notes: Loss bounds allow for the input synchronisers
`timescale 1ns/1ps
`default_nettype none
module srxl_top_chk
(
    input wire logic clk_in,                // Clock
    input wire logic srst_in,               // Reset
    input wire logic psel_in,               // APB
    input wire logic penable_in,            // APB
    input wire logic pwrite_in,             // APB
    input wire logic [11:0] paddr_in,       // APB
    input wire logic [31:0] pwdata_in,      // APB
    input wire logic [31:0] prdata_out,     // APB
    input wire logic pready_out,            // APB
    input wire logic pslverr_out,           // APB
    input wire logic serial_rx_in,          // Line
    input wire logic local_ref_clk_in,      // Reference
    input wire logic ext_signal_detect_in,  // Detect
    input wire logic rx_data_disable_in,    // Disable
    input wire logic [3:0] rx_par_data_out, // Word
    input wire logic rx_par_clk_out,        // Word clock
    input wire logic recovery_lock_ind_out, // Lock
    input wire logic sig_loss_out,          // Loss
    input wire logic irq_out                // Interrupt
);
    logic sd_q;
    logic pclk_q;
    logic [3:0] calm;
    logic [9:0] idle;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    // Loss may only move shortly after the detect pin or a register write
    always_ff @(posedge clk_in)
    begin
        sd_q <= ext_signal_detect_in;
        pclk_q <= rx_par_clk_out;
        if (srst_in || sd_q != ext_signal_detect_in || (pready_out && pwrite_in))
            calm <= 4'h0;
        else if (calm != 4'hf)
            calm <= calm + 4'h1;
        if (srst_in || pclk_q != rx_par_clk_out)
            idle <= 10'h0;
        else if (idle != 10'h3ff)
            idle <= idle + 10'h1;
    end
    disable_zero_a: assert property (rx_data_disable_in |-> rx_par_data_out == 4'h0)
        else $error("word not zero while disabled");
    ready_wait_a: assert property ($rose(psel_in && penable_in) |-> !pready_out ##1 pready_out)
        else $error("ready not after one wait state");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
        else $error("read data outside answer");
    loss_unlock_a: assert property (sig_loss_out ##1 sig_loss_out |-> !recovery_lock_ind_out)
        else $error("lock held during signal loss");
    lock_clean_a: assert property ($rose(recovery_lock_ind_out) |-> !sig_loss_out)
        else $error("lock gained during signal loss");
    loss_cause_a: assert property ($changed(sig_loss_out) |-> calm < 4'h8)
        else $error("loss moved without cause");
    word_clock_a: assert property (idle < 10'h12c)
        else $error("word clock stopped");
endmodule // srxl_top_chk
bind srxl_top srxl_top_chk srxl_top_chk_inst
(
    .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .serial_rx_in(serial_rx_in), .local_ref_clk_in(local_ref_clk_in),
    .ext_signal_detect_in(ext_signal_detect_in), .rx_data_disable_in(rx_data_disable_in),
    .rx_par_data_out(rx_par_data_out), .rx_par_clk_out(rx_par_clk_out),
    .recovery_lock_ind_out(recovery_lock_ind_out), .sig_loss_out(sig_loss_out),
    .irq_out(irq_out)
);
`default_nettype wire

// ---- dv/tb.sv ----
// Purpose: Self-checking bench of the receive lock block
// Assumes: Far model runs at the error-correction rate
// Notes: Lock needs whole measuring windows, so the run is long
`timescale 1ns/1ps
`default_nettype none
`include "srxl_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic sd = 1'b0;
    logic dis = 1'b0;
    logic [3:0] nib = 4'h5;
    logic [31:0] prdata, rd;
    logic pready, pslverr, serial, refclk, pclk, lock, loss, irq, err;
    logic [3:0] word, word_q;
    logic [31:0] rnd;
    int bad_count = 0;
    int checks = 0;
    int seed = 15;
    int cyc = 0;
    int falls = 0;
    time t0;
    always #2 clk_in = ~clk_in;
    always @(negedge pclk) falls++;
    srxl_top srxl_top_inst
    (
        .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .serial_rx_in(serial),
        .local_ref_clk_in(refclk), .ext_signal_detect_in(sd), .rx_data_disable_in(dis),
        .rx_par_data_out(word), .rx_par_clk_out(pclk), .recovery_lock_ind_out(lock),
        .sig_loss_out(loss), .irq_out(irq)
    );
    srxl_far_model srxl_far_model_inst
    (
        .clk_in(clk_in), .nib_in(nib), .serial_out(serial), .ref_out(refclk)
    );
    function automatic logic is_rot(input logic [3:0] n, input logic [3:0] w);
        return w == n || w == {n[2:0], n[3]} || w == {n[1:0], n[3:2]} || w == {n[0], n[3:1]};
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic done(input string n);
        $display("test %s done", n);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Lock takes up to two measuring windows of about 29k cycles each
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 95000)
        begin
            bad_count++;
            stop_test();
        end
    end
    initial
    begin
        do nib = 4'($random(seed)); while (nib == 4'h0 || nib == 4'hf);
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        apb(1'b0, `SRXL_ADDR_CTRL, 32'h0);
        `CHK("ctrl_reset", 32'h0, rd)
        apb(1'b0, `SRXL_ADDR_INT_MASK, 32'h0);
        `CHK("mask_reset", 32'h0, rd)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped_err", 1'b1, err)
        rnd = $random(seed);
        apb(1'b1, `SRXL_ADDR_INT_MASK, rnd);
        apb(1'b0, `SRXL_ADDR_INT_MASK, 32'h0);
        `CHK("mask_rw", rnd & 32'h7, rd)
        done("registers");
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, `SRXL_ADDR_CTRL, 32'(i[1]));
            sd <= i[0];
            repeat (8) @(posedge clk_in);
            `CHK("loss_pin", i[0] ^ i[1], loss)
            apb(1'b0, `SRXL_ADDR_STATUS, 32'h0);
            `CHK("loss_status", i[0] ^ i[1], rd[0])
        end
        done("polarity");
        apb(1'b1, `SRXL_ADDR_INT_MASK, 32'h0);
        apb(1'b0, `SRXL_ADDR_INT_STAT, 32'h0);
        `CHK("loss_event", 1'b1, rd[0])
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b1, `SRXL_ADDR_INT_MASK, 32'h1);
        repeat (2) @(posedge clk_in);
        `CHK("irq_set", 1'b1, irq)
        apb(1'b1, `SRXL_ADDR_INT_STAT, 32'h1);
        repeat (2) @(posedge clk_in);
        `CHK("irq_clear", 1'b0, irq)
        done("interrupt");
        apb(1'b1, `SRXL_ADDR_CTRL, 32'hc);
        sd <= 1'b0;
        apb(1'b1, `SRXL_ADDR_INT_STAT, 32'h7);
        apb(1'b1, `SRXL_ADDR_INT_MASK, 32'h7);
        while (lock !== 1'b1) @(posedge clk_in);
        apb(1'b0, `SRXL_ADDR_STATUS, 32'h0);
        `CHK("status_lock", 4'he, rd[3:0])
        `CHK("irq_lock", 1'b1, irq)
        repeat (3) @(negedge pclk);
        #1;
        `CHK("word_lanes", 1'b1, is_rot(nib, word))
        t0 = $time;
        word_q = word;
        @(negedge pclk);
        #1;
        `CHK("word_rate", 64'd28, ($time - t0) / 4)
        `CHK("word_fixed", word_q, word)
        @(posedge clk_in);
        dis <= 1'b1;
        #1;
        `CHK("disable", 4'h0, word)
        @(posedge clk_in);
        dis <= 1'b0;
        done("lock");
        apb(1'b1, `SRXL_ADDR_CTRL, 32'he);
        falls = 0;
        sd <= 1'b1;
        repeat (8) @(posedge clk_in);
        `CHK("lock_drop", 1'b0, lock)
        `CHK("mute", 4'h0, word)
        `CHK("loss_on", 1'b1, loss)
        apb(1'b0, `SRXL_ADDR_INT_STAT, 32'h0);
        `CHK("events", 3'h7, rd[2:0])
        repeat (200) @(posedge clk_in);
        `CHK("clock_kept", 1'b1, falls > 4)
        `CHK("mute_held", 4'h0, word)
        // Standard rate: reference-derived word clock is four bits of eight clocks
        apb(1'b1, `SRXL_ADDR_CTRL, 32'h2);
        repeat (250) @(posedge clk_in);
        @(negedge pclk);
        t0 = $time;
        @(negedge pclk);
        #1;
        `CHK("std_rate", 64'd32, ($time - t0 - 1) / 4)
        `CHK("mute_std", 4'h0, word)
        done("loss");
        stop_test();
    end
endmodule // tb
`default_nettype wire
